//--- core/ebl_boot_loader.sv
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
module ebl_boot_loader #(
	parameter int          DATA_W      = 48,
	parameter int          LANE_LSB    = 16,
	parameter logic [31:0] EXT_BASE    = 32'h0040_0000,
	parameter logic [31:0] INT_BASE    = 32'h0002_0000,
	parameter logic [31:0] CTRL_RESET  = 32'h0000_02a1,
	parameter logic [31:0] RESET_VEC   = 32'h0002_0004,
	parameter logic [31:0] KERNEL_BASE = 32'h0002_0000
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              reset_n,
	// Boot straps
	input  wire logic              eprom_boot_strap,
	input  wire logic              link_boot_strap,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// External bus
	output logic [31:0]            extAddr,
	input  wire logic [DATA_W-1:0] extData,
	output logic                   readStrobeHigh_n,
	output logic                   bootMemSelect_n,
	output logic                   bootMemSelectOe,
	output logic                   normalSelectEnable,
	// Acknowledge pin
	input  wire logic              ackIn,
	output logic                   ackOut,
	output logic                   ackOe,
	// Internal memory write
	output logic                   memWrEn,
	output logic [31:0]            memWrAddr,
	output logic [47:0]            memWrData,
	// Core
	output logic                   coreIdle,
	output logic [31:0]            programCounter,
	output logic                   bootIrq,
	input  wire logic              interrupt_return
);
	if (LANE_LSB < 0 || LANE_LSB > DATA_W - 8) begin : g_lane_check
		$error("byte lane outside data bus");
	end

	////////////////////////////////////////////////////////////////////////////
	logic [1:0]           rstPipe;
	logic                 rst_n;
	logic                 captured;
	logic                 epromBoot;
	logic                 bootStart;
	logic                 boot_select_enable;
	logic [1:0]           unbanked_wait_mode;
	logic [3:0]           unbanked_wait_states;
	logic [31:0]          boot_channel_control_a;
	logic [15:0]          internal_word_count;
	logic [15:0]          external_word_count;
	logic [31:0]          intAddr;
	logic                 busy;
	logic                 ackKept;
	logic                 waitDone;
	logic                 timerLoad;
	logic                 byteTaken;
	logic                 wordValid;
	logic [47:0]          packedWord;
	logic                 wrEn;
	logic                 swStart;
	ebl_pkg::ebl_state_t  state;

	// Release is clean: asynchronous assert, two-flop deassert
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstPipe <= 2'h0;
		end else begin
			rstPipe <= {rstPipe[0], 1'b1};
		end
	end
	assign rst_n = rstPipe[1];

	// Straps are read in the first cycle after release
	assign bootStart = !captured && eprom_boot_strap && !link_boot_strap;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			captured <= 1'b0;
			epromBoot <= 1'b0;
		end else if (!captured) begin
			captured <= 1'b1;
			epromBoot <= eprom_boot_strap && !link_boot_strap;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign wrEn = psel && penable && pwrite;
	// A software start of byte packing needs the select enable set
	assign swStart = wrEn && paddr == ebl_pkg::CHCTRL_OFS && pwdata[ebl_pkg::EN_BIT]
		&& boot_select_enable && !busy;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_select_enable <= 1'b0;
			unbanked_wait_mode <= ebl_pkg::WM_BOTH;
			unbanked_wait_states <= ebl_pkg::WS_RESET;
		end else if (bootStart) begin
			boot_select_enable <= 1'b1;
		end else if (wrEn && paddr == ebl_pkg::SYSCFG_OFS) begin
			boot_select_enable <= pwdata[ebl_pkg::BSE_BIT];
			unbanked_wait_mode <= pwdata[ebl_pkg::WM_LSB +: 2];
			unbanked_wait_states <= pwdata[ebl_pkg::WS_LSB +: 4];
		end
	end

	// Packing field is stored but never steers the datapath
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_channel_control_a <= CTRL_RESET;
		end else if (wrEn && paddr == ebl_pkg::CHCTRL_OFS) begin
			boot_channel_control_a <= pwdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus writes to parameters are ignored while the channel runs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			external_word_count <= ebl_pkg::ECNT_RESET;
			extAddr <= EXT_BASE;
		end else if (byteTaken) begin
			external_word_count <= external_word_count - 16'h1;
			extAddr <= extAddr + 32'h1;
		end else if (wrEn && !busy && paddr == ebl_pkg::ECNT_OFS) begin
			external_word_count <= pwdata[15:0];
		end else if (wrEn && !busy && paddr == ebl_pkg::EADDR_OFS) begin
			extAddr <= pwdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			internal_word_count <= ebl_pkg::ICNT_RESET;
			intAddr <= INT_BASE;
		end else if (wordValid) begin
			internal_word_count <= internal_word_count - 16'h1;
			intAddr <= intAddr + 32'h1;
		end else if (wrEn && !busy && paddr == ebl_pkg::ICNT_OFS) begin
			internal_word_count <= pwdata[15:0];
		end else if (wrEn && !busy && paddr == ebl_pkg::IADDR_OFS) begin
			intAddr <= pwdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Keeper follows the resolved line; reset drives it high
	assign ackOe = !rst_n;
	assign ackOut = 1'b1;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ackKept <= 1'b1;
		end else begin
			ackKept <= ackIn;
		end
	end

	ebl_wait_timer u_timer (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.load       (timerLoad),
		.run        (state == ebl_pkg::S_READ),
		.waitStates (unbanked_wait_states),
		.waitMode   (unbanked_wait_mode),
		.ackKept    (ackKept),
		.done       (waitDone)
	);

	////////////////////////////////////////////////////////////////////////////
	assign byteTaken = state == ebl_pkg::S_READ && waitDone;
	assign timerLoad = (state == ebl_pkg::S_IDLE && (bootStart || swStart))
		|| (state == ebl_pkg::S_GAP && external_word_count != 16'h0);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ebl_pkg::S_IDLE;
			busy <= 1'b0;
			bootIrq <= 1'b0;
		end else begin
			bootIrq <= 1'b0;
			case (state)
				ebl_pkg::S_IDLE: begin
					if (bootStart || swStart) begin
						state <= ebl_pkg::S_READ;
						busy <= 1'b1;
					end
				end
				ebl_pkg::S_READ: begin
					if (waitDone) begin
						state <= ebl_pkg::S_GAP;
					end
				end
				ebl_pkg::S_GAP: begin
					if (external_word_count == 16'h0) begin
						state <= ebl_pkg::S_FINISH;
					end else begin
						state <= ebl_pkg::S_READ;
					end
				end
				ebl_pkg::S_FINISH: begin
					// Last word has been written by now
					state <= ebl_pkg::S_IDLE;
					busy <= 1'b0;
					bootIrq <= 1'b1;
				end
				default: state <= ebl_pkg::S_IDLE;
			endcase
		end
	end

	ebl_byte_packer u_packer (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.clear     (state == ebl_pkg::S_IDLE),
		.byteValid (byteTaken),
		.byteIn    (extData[LANE_LSB +: 8]),
		.wordValid (wordValid),
		.word      (packedWord)
	);

	assign memWrEn = wordValid;
	assign memWrData = packedWord;
	assign memWrAddr = intAddr;

	////////////////////////////////////////////////////////////////////////////
	assign readStrobeHigh_n = state != ebl_pkg::S_READ;
	assign bootMemSelectOe = epromBoot;
	// Core accesses never reach this pin, only channel reads
	assign bootMemSelect_n = !(boot_select_enable && state == ebl_pkg::S_READ);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			normalSelectEnable <= 1'b0;
		end else begin
			// Held off until the straps are taken, so no select wakes as boot starts
			normalSelectEnable <= captured && !(boot_select_enable && busy);
		end
	end

	// Core sleeps at the reset vector until the boot interrupt returns
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			coreIdle <= 1'b0;
			programCounter <= RESET_VEC;
		end else if (bootStart) begin
			coreIdle <= 1'b1;
		end else if (interrupt_return && coreIdle && !busy) begin
			coreIdle <= 1'b0;
			programCounter <= KERNEL_BASE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign pready = 1'b1;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= 1'b0;
			if (paddr == ebl_pkg::SYSCFG_OFS) begin
				prdata <= {25'h0, unbanked_wait_states, unbanked_wait_mode, boot_select_enable};
			end else if (paddr == ebl_pkg::CHCTRL_OFS) begin
				prdata <= boot_channel_control_a;
			end else if (paddr == ebl_pkg::ICNT_OFS) begin
				prdata <= {16'h0, internal_word_count};
			end else if (paddr == ebl_pkg::ECNT_OFS) begin
				prdata <= {16'h0, external_word_count};
			end else if (paddr == ebl_pkg::IADDR_OFS) begin
				prdata <= intAddr;
			end else if (paddr == ebl_pkg::EADDR_OFS) begin
				prdata <= extAddr;
			end else if (paddr == ebl_pkg::STATUS_OFS) begin
				prdata <= {28'h0, coreIdle, epromBoot, !busy && captured, busy};
			end else begin
				prdata <= 32'h0;
				pslverr <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	property p_strobe_len;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(readStrobeHigh_n) && unbanked_wait_states == 4'h6
			&& unbanked_wait_mode == ebl_pkg::WM_INT |-> !readStrobeHigh_n [*7] ##1 readStrobeHigh_n;
	endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("read strobe not seven cycles");

	property p_reset_counts;
		@(posedge core_clk) $rose(rst_n) |-> internal_word_count == 16'h0100
			&& external_word_count == 16'h0600 && boot_channel_control_a == CTRL_RESET;
	endproperty
	a_reset_counts: assert property (p_reset_counts) else $error("bad reset parameters");

	property p_dma_only_select;
		@(posedge core_clk) disable iff (!rst_n)
		!bootMemSelect_n |-> busy && state == ebl_pkg::S_READ;
	endproperty
	a_dma_only_select: assert property (p_dma_only_select) else $error("select without transfer");

	property p_addr_step;
		@(posedge core_clk) disable iff (!rst_n)
		byteTaken |=> extAddr == $past(extAddr) + 32'h1
			&& external_word_count == $past(external_word_count) - 16'h1;
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("address or count did not step");

	property p_irq_at_zero;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(bootIrq) |-> external_word_count == 16'h0 && !busy;
	endproperty
	a_irq_at_zero: assert property (p_irq_at_zero) else $error("interrupt before counts done");

	property p_ack_reset;
		@(posedge core_clk) !rst_n |-> ackOe && ackOut;
	endproperty
	a_ack_reset: assert property (p_ack_reset) else $error("ack not driven high in reset");

	property p_selects_off;
		@(posedge core_clk) disable iff (!rst_n)
		busy && boot_select_enable |=> !normalSelectEnable;
	endproperty
	a_selects_off: assert property (p_selects_off) else $error("normal selects live in boot");

	property p_word_addr;
		@(posedge core_clk) disable iff (!rst_n)
		wordValid |=> intAddr == $past(intAddr) + 32'h1;
	endproperty
	a_word_addr: assert property (p_word_addr) else $error("internal address did not step");

	property p_no_early_select;
		@(posedge core_clk) disable iff (!rst_n)
		bootStart |=> !normalSelectEnable;
	endproperty
	a_no_early_select: assert property (p_no_early_select) else $error("selects on at start");

	property p_idle_vector;
		@(posedge core_clk) disable iff (!rst_n)
		coreIdle && busy |-> programCounter == RESET_VEC;
	endproperty
	a_idle_vector: assert property (p_idle_vector) else $error("core left reset vector");

	property p_icnt_step;
		@(posedge core_clk) disable iff (!rst_n)
		wordValid |=> internal_word_count == $past(internal_word_count) - 16'h1;
	endproperty
	a_icnt_step: assert property (p_icnt_step) else $error("word count did not step");
endmodule // ebl_boot_loader

//--- core/ebl_byte_packer.sv
`timescale 1ns/1ps
module ebl_byte_packer (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Byte side
	input  wire logic        clear,
	input  wire logic        byteValid,
	input  wire logic [7:0]  byteIn,
	// Word side
	output logic             wordValid,
	output logic [47:0]      word
);
	logic [2:0] count;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 3'h0;
			wordValid <= 1'b0;
			word <= 48'h0;
		end else begin
			wordValid <= 1'b0;
			if (clear) begin
				count <= 3'h0;
			end else if (byteValid) begin
				// Shift right so the first byte lands in the low lane
				word <= {byteIn, word[47:8]};
				wordValid <= count == ebl_pkg::LAST_BYTE;
				count <= (count == ebl_pkg::LAST_BYTE) ? 3'h0 : count + 3'h1;
			end
		end
	end

	property p_six_bytes;
		@(posedge core_clk) disable iff (!rst_n)
		byteValid && !clear && count == ebl_pkg::LAST_BYTE |=> wordValid;
	endproperty
	a_six_bytes: assert property (p_six_bytes) else $error("word not emitted after six bytes");
endmodule // ebl_byte_packer

//--- core/ebl_pkg.sv
// Functional notes
// - Eprom strap high, link low: select pin drives
// - Acknowledge held high during reset, then kept
// - Internal word count resets to 0x0100
// - External byte count resets to 0x600
// - Boot channel active after reset, control 0x2A1
// - Eprom address starts at base, increments per byte
// - Bytes packed low first into 48-bit words
// - Packing field ignored during eprom boot
// - Read strobe lasts seven cycles, six waits
// - Bytes sampled from one fixed data lane
// - Core idles at reset vector during boot
// - Eprom selected, other selects disabled at boot
// - Both counters decrement per transfer
// - Counters zero: stop, interrupt, return to kernel
// - Clearing select enable restores normal selects
// - Byte packing only with select enable set
// - Boot select asserts only for channel transfers
// - Reset wait mode needs count and acknowledge
// - Low acknowledge holds access off indefinitely
package ebl_pkg;
	localparam logic [7:0]  SYSCFG_OFS = 8'h00;
	localparam logic [7:0]  CHCTRL_OFS = 8'h04;
	localparam logic [7:0]  ICNT_OFS   = 8'h08;
	localparam logic [7:0]  ECNT_OFS   = 8'h0c;
	localparam logic [7:0]  IADDR_OFS  = 8'h10;
	localparam logic [7:0]  EADDR_OFS  = 8'h14;
	localparam logic [7:0]  STATUS_OFS = 8'h18;
	localparam int          BSE_BIT    = 0;
	localparam int          WM_LSB     = 1;
	localparam int          WS_LSB     = 3;
	localparam int          EN_BIT     = 0;
	localparam int          PACK_LSB   = 6;
	localparam logic [1:0]  WM_BOTH    = 2'h0;
	localparam logic [1:0]  WM_INT     = 2'h1;
	localparam logic [1:0]  WM_ACK     = 2'h2;
	localparam logic [3:0]  WS_RESET   = 4'h6;
	localparam logic [15:0] ICNT_RESET = 16'h0100;
	localparam logic [15:0] ECNT_RESET = 16'h0600;
	localparam logic [2:0]  LAST_BYTE  = 3'h5;
	typedef enum {S_IDLE, S_READ, S_GAP, S_FINISH} ebl_state_t;
endpackage

//--- core/ebl_wait_timer.sv
`timescale 1ns/1ps
module ebl_wait_timer (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	// Control
	input  wire logic       load,
	input  wire logic       run,
	input  wire logic [3:0] waitStates,
	input  wire logic [1:0] waitMode,
	input  wire logic       ackKept,
	// Result
	output logic            done
);
	logic [3:0] cnt;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
		end else if (load) begin
			cnt <= waitStates;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end

	// A low kept acknowledge never lets a mode needing it finish
	always_comb begin
		case (waitMode)
			ebl_pkg::WM_BOTH: done = run && cnt == 4'h0 && ackKept;
			ebl_pkg::WM_INT:  done = run && cnt == 4'h0;
			ebl_pkg::WM_ACK:  done = run && ackKept;
			default:          done = run && (cnt == 4'h0 || ackKept);
		endcase
	end

	property p_hold_off;
		@(posedge core_clk) disable iff (!rst_n)
		run && waitMode == ebl_pkg::WM_BOTH && !ackKept |-> !done;
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("access ended with ack low");
endmodule // ebl_wait_timer

//--- tb/ebl_eprom_model.sv
`timescale 1ns/1ps
module ebl_eprom_model #(
	parameter int          DATA_W   = 48,
	parameter int          LANE_LSB = 16,
	parameter logic [31:0] EXT_BASE = 32'h0040_0000
) (
	// Bus
	input  wire logic              core_clk,
	input  wire logic              bootMemSelect_n,
	input  wire logic              readStrobeHigh_n,
	input  wire logic [31:0]       extAddr,
	output logic      [DATA_W-1:0] extData
);
	logic [7:0]        mem [0:2047];
	logic [DATA_W-1:0] noise = '0;
	logic [31:0]       ofs;
	////////////////////////////////////////////////////////////////////////////
	// Unselected bus moves every cycle, so a stale byte can never pass
	always_ff @(posedge core_clk) begin
		noise <= ~noise ^ DATA_W'(extAddr);
	end
	always_comb begin
		ofs = extAddr - EXT_BASE;
		extData = noise;
		if (!bootMemSelect_n && !readStrobeHigh_n)
			extData[LANE_LSB +: 8] = mem[ofs[10:0]];
	end
endmodule // ebl_eprom_model

//--- tb/eprom_boot_dma_loader_bench.sv
`timescale 1ns/1ps
module eprom_boot_dma_loader_bench;
	localparam logic [31:0] EXT_BASE = 32'h0040_0000;
	localparam logic [31:0] INT_BASE = 32'h0002_0000;
	localparam logic [31:0] RST_VEC  = 32'h0002_0004;
	localparam logic [31:0] KBASE    = 32'h0002_0000;
	// Stand-in encoding for the no-operation word
	localparam logic [47:0] IDLE_WORD = 48'h0;
	logic        core_clk = 0, reset_n = 0, eprom_boot_strap = 1, link_boot_strap = 0;
	logic        psel = 0, penable = 0, pwrite = 0, interrupt_return = 0, ackLow = 0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0, prdata, extAddr, memWrAddr, programCounter, rd;
	logic [31:0] rs = 32'h2232, expAddr = EXT_BASE, expIAddr = INT_BASE, curAddr;
	logic [47:0] extData, memWrData, w;
	logic        pready, pslverr, readStrobeHigh_n, bootMemSelect_n, bootMemSelectOe, er;
	logic        normalSelectEnable, ackIn, ackOut, ackOe, memWrEn, coreIdle, bootIrq;
	logic        selOk = 1;
	int          failures = 0, samples_checked = 0, words = 0, bytes = 0, lowCnt = 0, irqs = 0;
	int          q[$];
	int          expLen = 7;
	assign ackIn = ackOe ? ackOut : !ackLow;
	ebl_boot_loader #(.EXT_BASE(EXT_BASE), .INT_BASE(INT_BASE), .RESET_VEC(RST_VEC),
		.KERNEL_BASE(KBASE)) i_ebl_boot_loader (.core_clk, .reset_n, .eprom_boot_strap,
		.link_boot_strap, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .extAddr, .extData, .readStrobeHigh_n, .bootMemSelect_n, .bootMemSelectOe,
		.normalSelectEnable, .ackIn, .ackOut, .ackOe, .memWrEn, .memWrAddr, .memWrData,
		.coreIdle, .programCounter, .bootIrq, .interrupt_return);
	ebl_eprom_model #(.EXT_BASE(EXT_BASE)) i_ebl_eprom_model (.core_clk, .bootMemSelect_n,
		.readStrobeHigh_n, .extAddr, .extData);
	initial forever #2 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////////
	function logic [7:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs[7:0];
	endfunction
	task chk(input string n, input logic [47:0] e, input logic [47:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task close_out;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			close_out;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask
	task waitw(input int tgt);
		int n;
		n = 0;
		while (words < tgt && n < 20000) begin
			@(posedge core_clk);
			n++;
		end
		if (words < tgt) begin
			failures++;
			close_out;
		end
	endtask
	task do_reset(input logic eb, input logic lb);
		reset_n <= 1'b0;
		eprom_boot_strap <= eb;
		link_boot_strap <= lb;
		repeat (3) @(posedge core_clk);
		chk("ack drive", 2'b11, {ackOe, ackOut});
		chk("reset pc", RST_VEC, programCounter);
		chk("reset selects", 2'b11, {readStrobeHigh_n, bootMemSelect_n});
		reset_n <= 1'b1;
		// Straps are taken at the third edge; what they set shows right after it, before the fourth
		repeat (4) @(posedge core_clk);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Reference: every finished read pushes the stored byte, every word pops six
	always @(posedge core_clk) begin
		if (reset_n !== 1'b1)
			lowCnt = 0;
		else if (readStrobeHigh_n === 1'b0) begin
			lowCnt++;
			curAddr = extAddr;
			selOk = selOk && (bootMemSelect_n === 1'b0);
		end else if (lowCnt > 0) begin
			chk("strobe cycles", expLen, lowCnt);
			chk("select with strobe", 1, selOk);
			chk("eprom addr", expAddr, curAddr);
			q.push_back(i_ebl_eprom_model.mem[curAddr - EXT_BASE]);
			expAddr++;
			bytes++;
			lowCnt = 0;
			selOk = 1;
		end
		if (memWrEn === 1'b1) begin
			w = '0;
			for (int k = 0; k < 6; k++)
				w[8*k +: 8] = (q.size() > 0) ? 8'(q.pop_front()) : 8'h00;
			chk("word", w, memWrData);
			chk("word addr", expIAddr, memWrAddr);
			expIAddr++;
			words++;
		end
		if (bootIrq === 1'b1)
			irqs++;
	end
	initial begin
		repeat (60000) @(posedge core_clk);
		failures++;
		close_out;
	end
	initial begin
		for (int k = 0; k < 2048; k++)
			i_ebl_eprom_model.mem[k] = xs();
		// The word in the reset vector slot is never run, so it holds a no-operation
		for (int k = 0; k < 6; k++)
			i_ebl_eprom_model.mem[6*(RST_VEC - INT_BASE) + k] = IDLE_WORD[8*k +: 8];
		do_reset(1'b1, 1'b0);
		chk("select drive", 1, bootMemSelectOe);
		rdc("syscfg", ebl_pkg::SYSCFG_OFS, 32'h31);
		rdc("chctrl", ebl_pkg::CHCTRL_OFS, 32'h2a1);
		apb(1'b1, ebl_pkg::CHCTRL_OFS, 32'h2e1);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 33'h1_0000_0000, {er, rd});
		chk("core idle", {1'b1, RST_VEC}, {coreIdle, programCounter});
		chk("normal selects", 0, normalSelectEnable);
		waitw(256);
		repeat (4) @(posedge core_clk);
		chk("irq", 1, irqs);
		chk("bytes", 1536, bytes);
		rdc("icnt", ebl_pkg::ICNT_OFS, 32'h0);
		rdc("ecnt", ebl_pkg::ECNT_OFS, 32'h0);
		interrupt_return <= 1'b1;
		@(posedge core_clk);
		interrupt_return <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("kernel jump", {1'b0, KBASE}, {coreIdle, programCounter});
		apb(1'b1, ebl_pkg::SYSCFG_OFS, 32'h30);
		repeat (2) @(posedge core_clk);
		chk("selects back", 2'b11, {normalSelectEnable, bootMemSelect_n});
		apb(1'b1, ebl_pkg::CHCTRL_OFS, 32'h2a1);
		repeat (4) @(posedge core_clk);
		apb(1'b0, ebl_pkg::STATUS_OFS, 32'h0);
		chk("no byte start", 0, rd[0]);
		// Kernel moves to count-only waits, so a stuck acknowledge cannot stall it
		ackLow <= 1'b1;
		apb(1'b1, ebl_pkg::SYSCFG_OFS, 32'h33);
		apb(1'b1, ebl_pkg::ICNT_OFS, 32'h1);
		apb(1'b1, ebl_pkg::ECNT_OFS, 32'h6);
		apb(1'b1, ebl_pkg::IADDR_OFS, 32'h0002_0100);
		apb(1'b1, ebl_pkg::EADDR_OFS, EXT_BASE + 32'h40);
		expAddr = EXT_BASE + 32'h40;
		expIAddr = 32'h0002_0100;
		chk("select idle", 1, bootMemSelect_n);
		apb(1'b1, ebl_pkg::CHCTRL_OFS, 32'h2a1);
		waitw(257);
		// Acknowledge-only mode ends each read as soon as the kept acknowledge is high
		ackLow <= 1'b0;
		apb(1'b1, ebl_pkg::SYSCFG_OFS, 32'h35);
		apb(1'b1, ebl_pkg::ICNT_OFS, 32'h1);
		apb(1'b1, ebl_pkg::ECNT_OFS, 32'h6);
		apb(1'b1, ebl_pkg::IADDR_OFS, 32'h0002_0101);
		apb(1'b1, ebl_pkg::EADDR_OFS, EXT_BASE + 32'h80);
		expAddr = EXT_BASE + 32'h80;
		expIAddr = 32'h0002_0101;
		expLen = 1;
		apb(1'b1, ebl_pkg::CHCTRL_OFS, 32'h2a1);
		waitw(258);
		ackLow <= 1'b1;
		expAddr = EXT_BASE;
		expIAddr = INT_BASE;
		expLen = 7;
		do_reset(1'b1, 1'b0);
		repeat (100) @(posedge core_clk);
		chk("hung strobe", 0, readStrobeHigh_n);
		chk("hung words", 258, words);
		do_reset(1'b1, 1'b1);
		repeat (8) @(posedge core_clk);
		chk("reserved straps", 2'b01, {bootMemSelectOe, readStrobeHigh_n});
		close_out;
	end
endmodule // eprom_boot_dma_loader_bench
